// >>> verilog/stereo_agc_defs.vh
// Register offsets, field positions, reset values and timing constants
`ifndef STEREO_AGC_DEFS_VH
`define STEREO_AGC_DEFS_VH
// ============================================================
// Register offsets
`define ADDR_LEFT_NG      8'h1C
`define ADDR_RIGHT_LT     8'h1D
`define ADDR_RIGHT_MAX    8'h1E
`define ADDR_RIGHT_NG     8'h1F
`define ADDR_LEFT_GAIN    8'h20
`define ADDR_RIGHT_GAIN   8'h21
// ============================================================
// Reset values
`define RST_NG            8'h00
`define RST_LT            8'h00
`define RST_MAX           8'hFF
`define RST_GAIN          8'h00
// ============================================================
// Field positions
`define LT_ENABLE_BIT     7
`define LT_TARGET_HI      6
`define LT_TARGET_LO      4
`define LT_ATTACK_HI      3
`define LT_ATTACK_LO      2
`define LT_DECAY_HI       1
`define LT_DECAY_LO       0
`define MAX_GAIN_HI       7
`define MAX_GAIN_LO       1
`define NG_HYST_HI        7
`define NG_HYST_LO        6
`define NG_THR_HI         5
`define NG_THR_LO         1
`define NG_CLIP_BIT       0
// ============================================================
// Gain limits in half-dB steps
`define GAIN_MIN          8'hE8
`define GAIN_MAX_CODE     7'h76
`define GAIN_CEIL         8'h77
// Noise threshold for code 0, signed half-dB; code 1 lands on -30 dB
`define THR_BASE_HD       9'h1C8
// ============================================================
// Timing
`define CLK_PERIOD_NS     20
`define NS_PER_MS         1000000
`define STEPS_PER_TC      16
`endif

// >>> verilog/agc_channel.v
// One channel of the gain control loop
`timescale 1ns/100ps
`include "stereo_agc_defs.vh"
module agc_channel #(
   parameter CYC_PER_MS   = `NS_PER_MS / `CLK_PERIOD_NS,
   parameter STEPS_PER_TC = `STEPS_PER_TC
) (
   input  wire       clk,
   input  wire       reset_n,
   input  wire       enable,       // Loop on
   input  wire [2:0] target_code,  // Target level select
   input  wire [1:0] attack_code,  // Attack time select
   input  wire [1:0] decay_code,   // Decay time select
   input  wire [6:0] max_code,     // Gain ceiling, half-dB
   input  wire [1:0] hyst_code,    // Noise hysteresis
   input  wire [4:0] thr_code,     // Noise threshold
   input  wire       clip_step,    // Fast step on clip
   input  wire       double_rate,  // Double-rate audio mode
   input  wire [7:0] level,        // Input level, signed half-dB
   output reg  [7:0] gain_reg,     // Applied gain, signed half-dB
   output wire       saturated,    // Gain at ceiling
   output reg        silence_reg   // Below noise threshold
);

   // ============================================================
   // Decode functions
   // Target level in signed half-dB
   function [8:0] target_hd;
      input [2:0] c;
      begin
         case (c)
            3'h0:    target_hd = -9'sd11;
            3'h1:    target_hd = -9'sd16;
            3'h2:    target_hd = -9'sd20;
            3'h3:    target_hd = -9'sd24;
            3'h4:    target_hd = -9'sd28;
            3'h5:    target_hd = -9'sd34;
            3'h6:    target_hd = -9'sd40;
            default: target_hd = -9'sd48;
         endcase
      end
   endfunction

   // Cycles between gain steps for a time constant in ms
   function [31:0] step_cycles;
      input [31:0] ms;
      input        dra;
      reg   [31:0] c;
      begin
         c = (ms * CYC_PER_MS) / STEPS_PER_TC;
         // Double rate runs the loop twice as fast; times drift
         if (dra)
            c = c >> 1;
         if (c == 32'h0)
            c = 32'h1;
         step_cycles = c;
      end
   endfunction

   // ============================================================
   // Decoded settings
   wire [31:0] attack_ms;                  // Attack time, ms
   wire [31:0] decay_ms;                   // Decay time, ms
   wire [7:0]  ceil_gain;                  // Clamped ceiling
   wire [8:0]  thr_hd;                     // Threshold, half-dB
   wire [8:0]  thr_exit;                   // Threshold plus hysteresis
   wire [8:0]  out_lvl;                    // Level after gain
   wire [8:0]  tgt;                        // Target, half-dB

   assign attack_ms = (attack_code == 2'h0) ? 32'd8  :
                      (attack_code == 2'h1) ? 32'd11 :
                      (attack_code == 2'h2) ? 32'd16 : 32'd20;
   assign decay_ms  = (decay_code == 2'h0) ? 32'd100 :
                      (decay_code == 2'h1) ? 32'd200 :
                      (decay_code == 2'h2) ? 32'd400 : 32'd500;
   // Codes past 59.0 dB all cap at 59.5 dB
   assign ceil_gain = (max_code > `GAIN_MAX_CODE) ? `GAIN_CEIL
                                                  : {1'b0, max_code};
   // -30 dB at code 1, 2 dB lower per code
   assign thr_hd   = `THR_BASE_HD - {2'b00, thr_code, 2'b00};
   assign thr_exit = thr_hd + {6'h00, hyst_code, 1'b0};
   assign out_lvl  = {level[7], level} + {gain_reg[7], gain_reg};
   assign tgt      = target_hd(target_code);

   assign saturated = enable && (gain_reg == ceil_gain);

   // ============================================================
   // Step timer and gain loop
   reg [31:0] tick_cnt_reg;                // Cycles since last step
   wire       atk_due;                     // Attack step due
   wire       dec_due;                     // Decay step due
   wire       clipping;                    // Output above full scale

   assign atk_due  = (tick_cnt_reg + 32'h1) >=
                     step_cycles(attack_ms, double_rate);
   assign dec_due  = (tick_cnt_reg + 32'h1) >=
                     step_cycles(decay_ms, double_rate);
   assign clipping = clip_step && !out_lvl[8] && (out_lvl != 9'h000);

   // Gain moves toward target; forced to unity while disabled, kept from rising while silent
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gain_reg     <= `RST_GAIN;
         tick_cnt_reg <= 32'h0;
         silence_reg  <= 1'b0;
      end else begin
         // Noise gate with hysteresis on exit
         if (thr_code == 5'h00 || !enable)
            silence_reg <= 1'b0;
         else if (!silence_reg && $signed({level[7], level})
                  < $signed(thr_hd))
            silence_reg <= 1'b1;
         else if (silence_reg && $signed({level[7], level})
                  >= $signed(thr_exit))
            silence_reg <= 1'b0;
         if (!enable) begin
            // Off: unity gain, timer parked
            gain_reg     <= 8'h00;
            tick_cnt_reg <= 32'h0;
         end else if (clipping && gain_reg != `GAIN_MIN) begin
            // Clip stepping drops gain every cycle, no timer wait
            gain_reg     <= gain_reg - 8'h01;
            tick_cnt_reg <= 32'h0;
         end else if ($signed(gain_reg) > $signed(ceil_gain)) begin
            // Ceiling lowered under us: fall to it at once
            gain_reg     <= ceil_gain;
            tick_cnt_reg <= 32'h0;
         end else if ($signed(out_lvl) > $signed(tgt)) begin
            if (atk_due) begin
               tick_cnt_reg <= 32'h0;
               if (gain_reg != `GAIN_MIN)
                  gain_reg <= gain_reg - 8'h01;
            end else
               tick_cnt_reg <= tick_cnt_reg + 32'h1;
         end else if ($signed(out_lvl) < $signed(tgt)
                      && !silence_reg) begin
            // Silence keeps gain from rising so noise is not amplified
            if (dec_due) begin
               tick_cnt_reg <= 32'h0;
               if (gain_reg != ceil_gain)
                  gain_reg <= gain_reg + 8'h01;
            end else
               tick_cnt_reg <= tick_cnt_reg + 32'h1;
         end else
            tick_cnt_reg <= 32'h0;
      end
   end

endmodule // agc_channel

// >>> verilog/stereo_agc_control.v
// Stereo record-path gain control register bank and loops
`timescale 1ns/100ps
`include "stereo_agc_defs.vh"
module stereo_agc_control #(
   parameter CYC_PER_MS   = `NS_PER_MS / `CLK_PERIOD_NS,
   parameter STEPS_PER_TC = `STEPS_PER_TC
) (
   input  wire       CLK_SYS,
   input  wire       RESET_N,
   input  wire [7:0] REG_ADDR,       // Register offset
   input  wire       REG_WR,         // Write strobe
   input  wire [7:0] REG_WDATA,      // Write data
   input  wire       REG_RD,         // Read strobe
   output reg  [7:0] REG_RDATA,      // Read data, next cycle
   input  wire       LEFT_ENABLE,    // Left loop enable
   input  wire [2:0] LEFT_TARGET,    // Left target select
   input  wire [1:0] LEFT_ATTACK,    // Left attack select
   input  wire [1:0] LEFT_DECAY,     // Left decay select
   input  wire [6:0] LEFT_MAX_GAIN,  // Left gain ceiling
   input  wire       DOUBLE_RATE,    // Double-rate audio mode
   input  wire [7:0] LEFT_LEVEL,     // Left input level, half-dB
   input  wire [7:0] RIGHT_LEVEL,    // Right input level, half-dB
   output wire [7:0] LEFT_GAIN,      // Left applied gain
   output wire [7:0] RIGHT_GAIN,     // Right applied gain
   output wire       LEFT_SAT,       // Left at ceiling
   output wire       RIGHT_SAT,      // Right at ceiling
   output wire       LEFT_SILENCE,   // Left below threshold
   output wire       RIGHT_SILENCE   // Right below threshold
);

   // ============================================================
   // Control registers
   reg  [7:0] left_ng_reg;           // Left noise gate control
   reg  [7:0] right_lt_reg;          // Right level and timing
   reg  [7:0] right_max_reg;         // Right maximum gain
   reg  [7:0] right_ng_reg;          // Right noise gate control
   wire [7:0] left_gain;             // Left loop gain
   wire [7:0] right_gain;            // Right loop gain

   // Host writes; gain readback offsets ignore writes
   always @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         left_ng_reg   <= `RST_NG;
         right_lt_reg  <= `RST_LT;
         right_max_reg <= `RST_MAX;
         right_ng_reg  <= `RST_NG;
      end else if (REG_WR) begin
         case (REG_ADDR)
            `ADDR_LEFT_NG:  left_ng_reg   <= REG_WDATA;
            `ADDR_RIGHT_LT: right_lt_reg  <= REG_WDATA;
            // Bit 0 is stored as written; host keeps it zero
            `ADDR_RIGHT_MAX: right_max_reg <= REG_WDATA;
            `ADDR_RIGHT_NG: right_ng_reg  <= REG_WDATA;
            default: ;
         endcase
      end
   end

   // ============================================================
   // Read port, one cycle latency, unmapped reads zero
   always @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N)
         REG_RDATA <= 8'h00;
      else if (REG_RD) begin
         case (REG_ADDR)
            `ADDR_LEFT_NG:    REG_RDATA <= left_ng_reg;
            `ADDR_RIGHT_LT:   REG_RDATA <= right_lt_reg;
            `ADDR_RIGHT_MAX:  REG_RDATA <= right_max_reg;
            `ADDR_RIGHT_NG:   REG_RDATA <= right_ng_reg;
            `ADDR_LEFT_GAIN:  REG_RDATA <= left_gain;
            `ADDR_RIGHT_GAIN: REG_RDATA <= right_gain;
            default:          REG_RDATA <= 8'h00;
         endcase
      end
   end

   assign LEFT_GAIN  = left_gain;
   assign RIGHT_GAIN = right_gain;

   // ============================================================
   // Left loop: enable and timing come from outside this bank
   agc_channel #(
      .CYC_PER_MS   (CYC_PER_MS),
      .STEPS_PER_TC (STEPS_PER_TC)
   ) u_left (
      .clk          (CLK_SYS),
      .reset_n      (RESET_N),
      .enable       (LEFT_ENABLE),
      .target_code  (LEFT_TARGET),
      .attack_code  (LEFT_ATTACK),
      .decay_code   (LEFT_DECAY),
      .max_code     (LEFT_MAX_GAIN),
      .hyst_code    (left_ng_reg[`NG_HYST_HI:`NG_HYST_LO]),
      .thr_code     (left_ng_reg[`NG_THR_HI:`NG_THR_LO]),
      .clip_step    (left_ng_reg[`NG_CLIP_BIT]),
      .double_rate  (DOUBLE_RATE),
      .level        (LEFT_LEVEL),
      .gain_reg     (left_gain),
      .saturated    (LEFT_SAT),
      .silence_reg  (LEFT_SILENCE)
   );

   // ============================================================
   // Right loop: programmed from this bank except the shared DOUBLE_RATE
   agc_channel #(
      .CYC_PER_MS   (CYC_PER_MS),
      .STEPS_PER_TC (STEPS_PER_TC)
   ) u_right (
      .clk          (CLK_SYS),
      .reset_n      (RESET_N),
      .enable       (right_lt_reg[`LT_ENABLE_BIT]),
      .target_code  (right_lt_reg[`LT_TARGET_HI:`LT_TARGET_LO]),
      .attack_code  (right_lt_reg[`LT_ATTACK_HI:`LT_ATTACK_LO]),
      .decay_code   (right_lt_reg[`LT_DECAY_HI:`LT_DECAY_LO]),
      .max_code     (right_max_reg[`MAX_GAIN_HI:`MAX_GAIN_LO]),
      .hyst_code    (right_ng_reg[`NG_HYST_HI:`NG_HYST_LO]),
      .thr_code     (right_ng_reg[`NG_THR_HI:`NG_THR_LO]),
      .clip_step    (right_ng_reg[`NG_CLIP_BIT]),
      .double_rate  (DOUBLE_RATE),
      .level        (RIGHT_LEVEL),
      .gain_reg     (right_gain),
      .saturated    (RIGHT_SAT),
      .silence_reg  (RIGHT_SILENCE)
   );

endmodule // stereo_agc_control

// >>> sim/stereo_agc_control_asserts.sv
// Port-level checks for the stereo gain control register bank
`timescale 1ns/100ps
module stereo_agc_control_asserts #(
   parameter CYC_PER_MS   = 50000,
   parameter STEPS_PER_TC = 16
) (
   input logic       CLK_SYS,
   input logic       RESET_N,
   input logic [7:0] REG_ADDR,
   input logic       REG_RD,
   input logic [7:0] REG_RDATA,
   input logic       LEFT_ENABLE,
   input logic [6:0] LEFT_MAX_GAIN,
   input logic [7:0] LEFT_GAIN,
   input logic [7:0] RIGHT_GAIN,
   input logic       LEFT_SAT,
   input logic       RIGHT_SAT,
   input logic       LEFT_SILENCE
);
   // ==========================================================
   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);
   // Top ceiling codes fold onto 59.5 dB
   wire [7:0] left_ceil = (LEFT_MAX_GAIN > 7'h76) ? 8'h77
                                                  : {1'b0, LEFT_MAX_GAIN};
   AST_LEFT_SAT: assert property (
      LEFT_SAT == (LEFT_ENABLE && LEFT_GAIN == left_ceil))
      else $error("left saturation flag wrong");
   AST_RIGHT_SAT: assert property (
      RIGHT_SAT |-> $signed(RIGHT_GAIN) >= 0)
      else $error("right saturation with negative gain");
   AST_RIGHT_CEIL: assert property (
      $signed(RIGHT_GAIN) <= 119) else $error("right gain above 59.5 dB");
   AST_LEFT_FLOOR: assert property (
      $signed(LEFT_GAIN) >= -24) else $error("left gain below -12 dB");
   AST_LEFT_OFF: assert property (
      !LEFT_ENABLE [*2] |-> LEFT_GAIN == 8'h00 && !LEFT_SILENCE)
      else $error("disabled left loop not idle");
   // Only single half-dB steps while the ceiling stands still
   AST_LEFT_STEP: assert property (
      LEFT_ENABLE && $past(LEFT_ENABLE) && $stable(LEFT_MAX_GAIN) &&
      $past(LEFT_MAX_GAIN) == $past(LEFT_MAX_GAIN, 2) |->
      (LEFT_GAIN - $past(LEFT_GAIN)) inside {8'h00, 8'h01, 8'hFF})
      else $error("left gain jumped");
   AST_RD_LEFT: assert property (
      REG_RD && REG_ADDR == 8'h20 |=> REG_RDATA == $past(LEFT_GAIN))
      else $error("left gain readback wrong");
   AST_RD_RIGHT: assert property (
      REG_RD && REG_ADDR == 8'h21 |=> REG_RDATA == $past(RIGHT_GAIN))
      else $error("right gain readback wrong");
   AST_RD_HOLD: assert property (
      !REG_RD |=> $stable(REG_RDATA)) else $error("read data moved");
endmodule // stereo_agc_control_asserts

bind stereo_agc_control stereo_agc_control_asserts #(
   .CYC_PER_MS(CYC_PER_MS), .STEPS_PER_TC(STEPS_PER_TC)) u_chk (
   .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
   .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .LEFT_ENABLE(LEFT_ENABLE),
   .LEFT_MAX_GAIN(LEFT_MAX_GAIN), .LEFT_GAIN(LEFT_GAIN),
   .RIGHT_GAIN(RIGHT_GAIN), .LEFT_SAT(LEFT_SAT), .RIGHT_SAT(RIGHT_SAT),
   .LEFT_SILENCE(LEFT_SILENCE));

// >>> sim/tb_top.sv
// Self-checking bench for the stereo gain control register bank
`timescale 1ns/100ps
module tb_top;
   reg        CLK_SYS = 1'b0;
   reg        RESET_N = 1'b0;
   reg  [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00;
   reg        REG_WR = 1'b0, REG_RD = 1'b0;
   reg        LEFT_ENABLE = 1'b0, DOUBLE_RATE = 1'b0;
   reg  [2:0] LEFT_TARGET = 3'h0;
   reg  [1:0] LEFT_ATTACK = 2'h0, LEFT_DECAY = 2'h0;
   reg  [6:0] LEFT_MAX_GAIN = 7'h7F;
   reg  [7:0] LEFT_LEVEL = 8'h00, RIGHT_LEVEL = 8'h00;
   wire [7:0] REG_RDATA, LEFT_GAIN, RIGHT_GAIN;
   wire       LEFT_SAT, RIGHT_SAT, LEFT_SILENCE, RIGHT_SILENCE;
   integer    n_errors = 0, samples_checked = 0, i;
   reg  [7:0] lfsr = 8'h3C;   // Fixed seed keeps runs repeatable
   reg  [7:0] d;
   // Short counts so a full settle fits in a few thousand cycles
   stereo_agc_control #(.CYC_PER_MS(4), .STEPS_PER_TC(1)) dut (
      .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
      .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD),
      .REG_RDATA(REG_RDATA), .LEFT_ENABLE(LEFT_ENABLE),
      .LEFT_TARGET(LEFT_TARGET), .LEFT_ATTACK(LEFT_ATTACK),
      .LEFT_DECAY(LEFT_DECAY), .LEFT_MAX_GAIN(LEFT_MAX_GAIN),
      .DOUBLE_RATE(DOUBLE_RATE), .LEFT_LEVEL(LEFT_LEVEL),
      .RIGHT_LEVEL(RIGHT_LEVEL), .LEFT_GAIN(LEFT_GAIN),
      .RIGHT_GAIN(RIGHT_GAIN), .LEFT_SAT(LEFT_SAT), .RIGHT_SAT(RIGHT_SAT),
      .LEFT_SILENCE(LEFT_SILENCE), .RIGHT_SILENCE(RIGHT_SILENCE));
   // ==========================================================
   // Clock, helpers and bus tasks
   always #10 CLK_SYS = ~CLK_SYS;
   function [7:0] nxt(input [7:0] s);
      nxt = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // Settled gain at full-scale input: the target, floored at -12 dB
   function [7:0] settle(input [2:0] c);
      case (c)
         3'h0: settle = 8'hF5;
         3'h1: settle = 8'hF0;
         3'h2: settle = 8'hEC;
         default: settle = 8'hE8;   // Deeper targets hit the floor
      endcase
   endfunction
   task chk(input [7:0] seen, input [7:0] want);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== want) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, want);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] v);
      begin
         @(negedge CLK_SYS);
         REG_ADDR = a;
         REG_WDATA = v;
         REG_WR = 1'b1;
         @(negedge CLK_SYS);
         REG_WR = 1'b0;
      end
   endtask
   // Data lands at the read edge and holds, so sample a cycle later
   task rd_chk(input [7:0] a, input [7:0] want);
      begin
         @(negedge CLK_SYS);
         REG_ADDR = a;
         REG_RD = 1'b1;
         @(negedge CLK_SYS);
         REG_RD = 1'b0;
         @(negedge CLK_SYS);
         chk(REG_RDATA, want);
      end
   endtask
   task wait_cyc(input integer n);
      repeat (n) @(negedge CLK_SYS);
   endtask
   task end_of_test;
      begin
         $display("checks %0d errors %0d", samples_checked, n_errors);
         if (n_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   // ==========================================================
   // Watchdog, sized well above the expected run length
   initial begin
      #(40000 * 20);
      n_errors = n_errors + 1;
      end_of_test;
   end
   // ==========================================================
   // Main sequence
   initial begin
      wait_cyc(12);
      RESET_N = 1'b1;
      // Reset values, with unmapped holes on both sides
      for (i = 0; i < 9; i = i + 1)
         rd_chk(8'h1A + i[7:0], (i == 4) ? 8'hFF : 8'h00);
      // Random settings read back; right loop kept off here
      for (i = 0; i < 4; i = i + 1) begin
         lfsr = nxt(lfsr);
         d = (i == 1) ? (lfsr & 8'h7F) : (i == 2) ? (lfsr & 8'hFE) : lfsr;
         wr(8'h1C + i[7:0], d);
         rd_chk(8'h1C + i[7:0], d);
      end
      wr(8'h20, 8'h55);
      wr(8'h21, 8'hAA);
      rd_chk(8'h20, 8'h00);
      rd_chk(8'h21, 8'h00);
      // Every target code, random attack, decay and rate mode
      wr(8'h1E, 8'hFE);
      for (i = 0; i < 8; i = i + 1) begin
         lfsr = nxt(lfsr);
         DOUBLE_RATE = lfsr[7];
         LEFT_TARGET = i[2:0];
         LEFT_ATTACK = lfsr[1:0];
         LEFT_DECAY = lfsr[3:2];
         LEFT_ENABLE = 1'b1;
         wr(8'h1D, {1'b1, i[2:0], lfsr[1:0], lfsr[3:2]});
         wait_cyc(2100);
         rd_chk(8'h20, settle(i[2:0]));
         rd_chk(8'h21, settle(i[2:0]));
         LEFT_ENABLE = 1'b0;
         wr(8'h1D, 8'h00);
         wait_cyc(3);
         chk(RIGHT_GAIN, 8'h00);
      end
      DOUBLE_RATE = 1'b0;
      // Hot input with clip stepping: one step per cycle, not per 32
      wr(8'h1F, 8'h01);
      RIGHT_LEVEL = 8'h14;
      wr(8'h1D, 8'h80);
      wait_cyc(26);
      chk(RIGHT_GAIN, 8'hEC);
      // Quiet input climbs to a 5 dB ceiling, then the ceiling drops
      wr(8'h1D, 8'h00);
      wr(8'h1F, 8'h00);
      wr(8'h1E, 8'h14);
      RIGHT_LEVEL = 8'hC4;
      wr(8'h1D, 8'h80);
      wait_cyc(4400);
      chk(RIGHT_GAIN, 8'h0A);
      chk({7'h00, RIGHT_SAT}, 8'h01);
      wr(8'h1E, 8'h08);
      wait_cyc(3);
      chk(RIGHT_GAIN, 8'h04);
      // Silence gate: threshold off lets gain rise; -31 dB input sits
      // just under the -30 dB threshold, which freezes it
      wr(8'h1E, 8'hFE);
      RIGHT_LEVEL = 8'hC2;
      for (i = 0; i < 2; i = i + 1) begin
         wr(8'h1D, 8'h00);
         wr(8'h1F, i[0] ? 8'h42 : 8'h00);
         wr(8'h1D, 8'h80);
         wait_cyc(600);
         chk({7'h00, RIGHT_SILENCE}, i[7:0]);
         chk(RIGHT_GAIN, {7'h00, ~i[0]});
      end
      // 1 dB hysteresis: -29.5 dB stays silent, -29 dB leaves
      RIGHT_LEVEL = 8'hC5;
      wait_cyc(3);
      chk({7'h00, RIGHT_SILENCE}, 8'h01);
      RIGHT_LEVEL = 8'hC6;
      wait_cyc(3);
      chk({7'h00, RIGHT_SILENCE}, 8'h00);
      end_of_test;
   end
endmodule // tb_top
